// >>> cia_pkg.sv
// Package: register map, field positions and reset values of the interrupt aggregator
package cia_pkg;
   localparam int          CIA_ADDR_W         = 32;
   localparam int          CIA_DATA_W         = 8;
   localparam logic [31:0] CIA_OFS_EN_LOW     = 32'h11000000;
   localparam logic [31:0] CIA_OFS_EN_HIGH    = 32'h11000002;
   localparam logic [31:0] CIA_OFS_PEND_LOW   = 32'h11000004;
   localparam logic [31:0] CIA_OFS_PEND_HIGH  = 32'h11000006;
   localparam logic [7:0]  CIA_RST_EN_LOW     = 8'h00;
   localparam logic [7:0]  CIA_RST_EN_HIGH    = 8'h00;
   localparam logic [7:0]  CIA_RST_PEND_LOW   = 8'h00;
   localparam logic [7:0]  CIA_RST_PEND_HIGH  = 8'h00;
   localparam logic [3:0]  CIA_RST_EDGE_PREV  = 4'h8;   // Idle levels: timers low, acknowledge pin high
   localparam int          CIA_NUM_EDGE       = 4;
   localparam int          CIA_NUM_CAUSES     = 16;
   localparam logic [7:0]  CIA_EDGE_BITS_MASK = 8'h0F;
   // Register selector
   typedef enum logic [2:0] {
      CIA_SEL_NONE      = 3'h0,
      CIA_SEL_EN_LOW    = 3'h1,
      CIA_SEL_EN_HIGH   = 3'h3,
      CIA_SEL_PEND_LOW  = 3'h2,
      CIA_SEL_PEND_HIGH = 3'h6
   } cia_sel_type;
endpackage : cia_pkg

// >>> cia_edge_if.sv
// Interface: edge-latched cause bank signals between top and capture module
`timescale 1ns/100ps
interface cia_edge_if;
   import cia_pkg::*;
   logic [CIA_NUM_EDGE-1:0] level;
   logic [CIA_NUM_EDGE-1:0] clr;
   logic [CIA_NUM_EDGE-1:0] pend;
   modport top (output level, output clr, input pend);
   modport cap (input level, input clr, output pend);
endinterface : cia_edge_if

// >>> cia_edge_capture.sv
// Rising-edge capture of the four edge-latched interrupt causes
`timescale 1ns/100ps
module cia_edge_capture
   import cia_pkg::*;
(
   input wire logic clk,        // System clock
   input wire logic reset_n,    // Async reset, active low
   cia_edge_if.cap  edge_bus    // Levels in, clears in, pending out
);
   logic [CIA_NUM_EDGE-1:0] prev;
   logic [CIA_NUM_EDGE-1:0] next_prev;
   logic [CIA_NUM_EDGE-1:0] pend;
   logic [CIA_NUM_EDGE-1:0] next_pend;

   // ----------------------------------------------------------
   // Per-bit edge detect and sticky flag
   // ----------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < CIA_NUM_EDGE; i++)
      begin : g_bit
         // Set beats software clear in the same cycle
         always_comb
         begin
            next_prev[i] = edge_bus.level[i];
            if (edge_bus.level[i] && !prev[i])
               next_pend[i] = 1'b1;
            else if (edge_bus.clr[i])
               next_pend[i] = 1'b0;
            else
               next_pend[i] = pend[i];
         end
      end
   endgenerate

   // Registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prev <= CIA_RST_EDGE_PREV;
         pend <= CIA_RST_PEND_LOW[CIA_NUM_EDGE-1:0];
      end
      else
      begin
         prev <= next_prev;
         pend <= next_pend;
      end
   end

   assign edge_bus.pend = pend;
endmodule : cia_edge_capture

// >>> cia_irq_aggregator.sv
// Top: interrupt aggregator with enable/status registers and level request
`timescale 1ns/100ps
// What this block does
// - Sixteen causes merge into one request line.
// - Request is a level while enabled cause pends.
// - Status bits set regardless of enable.
// - Timer output rising edges latch bits 0-2.
// - Parallel acknowledge rising edge latches bit 3.
// - Writing 0 clears edge bits 0-3.
// - Low bits 4,5 follow UART interrupts.
// - Compact slot change is OR of bits 2,0.
// - Compact slot ready/irq drives low bit 7.
// - Slot A/B change ORs bits 3-0.
// - Slot A/B ready/irq drive high bits 1,3.
// - Keyboard complete flags drive high bits 4,5.
// - Mouse complete flags drive high bits 6,7.
// - Level-mirrored status bits are read-only.
module cia_irq_aggregator
   import cia_pkg::*;
(
   input  wire logic                       clk,                  // System clock, 10 MHz
   input  wire logic                       reset_n,              // Async reset, active low
   input  wire logic                       bus_sel,              // Register access strobe
   input  wire logic                       bus_write,            // 1 write, 0 read
   input  wire logic [cia_pkg::CIA_ADDR_W-1:0] bus_addr,         // Byte address
   input  wire logic [cia_pkg::CIA_DATA_W-1:0] bus_wdata,        // Write data
   output logic      [cia_pkg::CIA_DATA_W-1:0] bus_rdata,        // Read data, registered
   input  wire logic [2:0]                 timer_out,            // Timer channel 2..0 outputs
   input  wire logic                       parallel_ack_n,       // Parallel acknowledge, active low
   input  wire logic                       uart3_irq,            // First UART interrupt
   input  wire logic                       uart4_irq,            // Second UART interrupt
   input  wire logic [3:0]                 compact_card_slot_chg, // Compact slot change register bits
   input  wire logic                       compact_card_slot_ready_irq_n, // Compact slot ready/irq
   input  wire logic [3:0]                 slot_a_chg,           // Slot A change register bits
   input  wire logic [3:0]                 slot_b_chg,           // Slot B change register bits
   input  wire logic                       slot_a_ready_irq_n,   // Slot A ready/irq, active low
   input  wire logic                       slot_b_ready_irq_n,   // Slot B ready/irq, active low
   input  wire logic                       kbd_rx_done,          // Keyboard receive complete
   input  wire logic                       kbd_tx_done,          // Keyboard transmit complete
   input  wire logic                       mouse_rx_done,        // Mouse receive complete
   input  wire logic                       mouse_tx_done,        // Mouse transmit complete
   output logic                            host_level_irq_input_n // Merged request, active low
);
   import cia_pkg::*;

   // ----------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------
   function automatic cia_sel_type decode(input logic [CIA_ADDR_W-1:0] a);
      cia_sel_type s;
      case (a)
         CIA_OFS_EN_LOW:    s = CIA_SEL_EN_LOW;
         CIA_OFS_EN_HIGH:   s = CIA_SEL_EN_HIGH;
         CIA_OFS_PEND_LOW:  s = CIA_SEL_PEND_LOW;
         CIA_OFS_PEND_HIGH: s = CIA_SEL_PEND_HIGH;
         default:           s = CIA_SEL_NONE;
      endcase
      return s;
   endfunction : decode

   cia_sel_type              sel;
   logic [CIA_DATA_W-1:0]    en_low;
   logic [CIA_DATA_W-1:0]    en_high;
   logic [CIA_DATA_W-1:0]    next_en_low;
   logic [CIA_DATA_W-1:0]    next_en_high;
   logic [CIA_DATA_W-1:0]    next_rdata;
   logic [CIA_DATA_W-1:0]    pend_low;
   logic [CIA_DATA_W-1:0]    pend_high;
   logic [CIA_DATA_W-1:0]    lvl_low;
   logic [CIA_DATA_W-1:0]    next_lvl_low;
   logic [CIA_DATA_W-1:0]    next_pend_high;
   logic                     next_irq_n;
   logic                     irq_n;

   cia_edge_if edge_bus ();

   assign sel = decode(bus_addr);

   // ----------------------------------------------------------
   // Edge-latched causes, bits 0 to 3 of low status
   // ----------------------------------------------------------
   // Acknowledge taken on the pin's own rise, i.e. at its release
   assign edge_bus.level = {parallel_ack_n, timer_out};
   // Zero written to an edge bit clears it; ones leave it alone
   assign edge_bus.clr   = (bus_sel && bus_write && sel == CIA_SEL_PEND_LOW)
                           ? ~bus_wdata[CIA_NUM_EDGE-1:0] : '0;

   cia_edge_capture u_edge (
      .clk      (clk),
      .reset_n  (reset_n),
      .edge_bus (edge_bus)
   );

   // ----------------------------------------------------------
   // Level-mirrored causes, sampled each clock
   // ----------------------------------------------------------
   always_comb
   begin
      next_lvl_low    = '0;
      next_lvl_low[4] = uart3_irq;
      next_lvl_low[5] = uart4_irq;
      next_lvl_low[6] = compact_card_slot_chg[2] | compact_card_slot_chg[0];
      next_lvl_low[7] = ~compact_card_slot_ready_irq_n;
      next_pend_high[0] = |slot_a_chg;
      next_pend_high[1] = ~slot_a_ready_irq_n;
      next_pend_high[2] = |slot_b_chg;
      next_pend_high[3] = ~slot_b_ready_irq_n;
      next_pend_high[4] = kbd_rx_done;
      next_pend_high[5] = kbd_tx_done;
      next_pend_high[6] = mouse_rx_done;
      next_pend_high[7] = mouse_tx_done;
   end

   // Combined low status: edge bits below, read-only mirrors above
   assign pend_low = (lvl_low & ~CIA_EDGE_BITS_MASK) |
                     {4'h0, edge_bus.pend};

   // ----------------------------------------------------------
   // Enable registers and read data
   // ----------------------------------------------------------
   always_comb
   begin
      next_en_low  = en_low;
      next_en_high = en_high;
      next_rdata   = bus_rdata;
      if (bus_sel && bus_write)
      begin
         case (sel)
            CIA_SEL_EN_LOW:  next_en_low  = bus_wdata;
            CIA_SEL_EN_HIGH: next_en_high = bus_wdata;
            default:         ;
         endcase
      end
      else if (bus_sel)
      begin
         case (sel)
            CIA_SEL_EN_LOW:    next_rdata = en_low;
            CIA_SEL_EN_HIGH:   next_rdata = en_high;
            CIA_SEL_PEND_LOW:  next_rdata = pend_low;
            CIA_SEL_PEND_HIGH: next_rdata = pend_high;
            default:           next_rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Merged level request, active low
   // ----------------------------------------------------------
   always_comb
   begin
      // Level, not pulse: holds while any enabled cause pends
      next_irq_n = ~(|(pend_low & en_low) | |(pend_high & en_high));
   end

   // Registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         en_low    <= CIA_RST_EN_LOW;
         en_high   <= CIA_RST_EN_HIGH;
         lvl_low   <= CIA_RST_PEND_LOW;
         pend_high <= CIA_RST_PEND_HIGH;
         bus_rdata <= 8'h00;
         irq_n     <= 1'b1;
      end
      else
      begin
         en_low    <= next_en_low;
         en_high   <= next_en_high;
         lvl_low   <= next_lvl_low;
         pend_high <= next_pend_high;
         bus_rdata <= next_rdata;
         irq_n     <= next_irq_n;
      end
   end

   assign host_level_irq_input_n = irq_n;
endmodule : cia_irq_aggregator

// >>> cia_irq_checker.sv
// Checker: port properties of the interrupt aggregator
`timescale 1ns/100ps
module cia_irq_checker
   import cia_pkg::*;
(
   input wire logic        clk,                   // Clock
   input wire logic        reset_n,               // Reset
   input wire logic        bus_sel,               // Strobe
   input wire logic        bus_write,             // Direction
   input wire logic [31:0] bus_addr,              // Address
   input wire logic [7:0]  bus_wdata,             // Write data
   input wire logic [7:0]  bus_rdata,             // Read data
   input wire logic [2:0]  timer_out,             // Timers
   input wire logic        uart3_irq,             // UART
   input wire logic        kbd_tx_done,           // Keyboard
   input wire logic [3:0]  compact_card_slot_chg, // Change bits
   input wire logic        host_level_irq_input_n // Request
);
   logic [15:0] en;
   wire rd = bus_sel && !bus_write;
   wire wr = bus_sel && bus_write;
   wire pl = bus_addr == CIA_OFS_PEND_LOW;
   wire ph = bus_addr == CIA_OFS_PEND_HIGH;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Shadow of both enable registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         en <= 16'h0000;
      else if (wr && bus_addr == CIA_OFS_EN_LOW)
         en[7:0] <= bus_wdata;
      else if (wr && bus_addr == CIA_OFS_EN_HIGH)
         en[15:8] <= bus_wdata;
   end
   a_en_low_read: assert property (
      rd && bus_addr == CIA_OFS_EN_LOW |=> bus_rdata == $past(en[7:0])) else $error("enable low readback");
   a_en_high_read: assert property (
      rd && bus_addr == CIA_OFS_EN_HIGH |=> bus_rdata == $past(en[15:8])) else $error("enable high readback");
   a_mask_quiet: assert property (
      en == 16'h0000 |=> host_level_irq_input_n) else $error("request while all masked");
   a_uart_mirror: assert property (
      $past(reset_n) && $stable(uart3_irq) && rd && pl |=> bus_rdata[4] == $past(uart3_irq)) else $error("uart bit");
   a_kbd_mirror: assert property (
      $past(reset_n) && $stable(kbd_tx_done) && rd && ph |=> bus_rdata[5] == $past(kbd_tx_done)) else $error("kbd bit");
   a_chg_or: assert property (
      $past(reset_n) && $stable(compact_card_slot_chg) && rd && pl
      |=> bus_rdata[6] == $past(compact_card_slot_chg[2] | compact_card_slot_chg[0])) else $error("change bit");
   a_timer_edge: assert property (
      $rose(timer_out[0]) ##0 (en[0] && !bus_sel)[*4] |-> !host_level_irq_input_n) else $error("timer request");
   a_write_clear: assert property (
      (!timer_out[0])[*3] ##0 (wr && pl && !bus_wdata[0]) ##1 !timer_out[0] ##1 (rd && pl)
      |=> !bus_rdata[0]) else $error("edge bit not cleared");
   c_timer: cover property ($rose(timer_out[0]) && en[0]);
   c_clear: cover property (wr && pl);
   c_irq: cover property ($fell(host_level_irq_input_n));
endmodule : cia_irq_checker
bind cia_irq_aggregator cia_irq_checker cia_irq_checker_i (.*);

// >>> cia_host_model.sv
// Host model: level-sensitive interrupt input of the processor
`timescale 1ns/100ps
module cia_host_model
(
   input wire logic clk,     // Clock
   input wire logic reset_n, // Reset
   input wire logic irq_n,   // Request in
   output logic     irq_seen // Low level seen
);
   // Input detects a low level, never an edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_seen <= 1'b0;
      else
         irq_seen <= !irq_n;
   end
endmodule : cia_host_model

// >>> cia_irq_aggregator_tb.sv
// Testbench: registers, edge causes, level causes, request
`timescale 1ns/100ps
module cia_irq_aggregator_tb;
   import cia_pkg::*;
   localparam logic [20:0] lv_idle = 21'h1C000;
   logic clk, reset_n, bus_sel, bus_write, ack_n, irq_n, seen;
   logic [31:0] bus_addr;
   logic [7:0] bus_wdata, rdata, q;
   logic [2:0] tmr;
   logic [20:0] lv;
   int err_total, total_checks;
   cia_irq_aggregator cia_irq_aggregator_i (.clk(clk), .reset_n(reset_n), .bus_sel(bus_sel),
      .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(rdata),
      .timer_out(tmr), .parallel_ack_n(ack_n), .uart3_irq(lv[12]), .uart4_irq(lv[13]),
      .compact_card_slot_chg(lv[3:0]), .compact_card_slot_ready_irq_n(lv[14]), .slot_a_chg(lv[7:4]),
      .slot_b_chg(lv[11:8]), .slot_a_ready_irq_n(lv[15]), .slot_b_ready_irq_n(lv[16]),
      .kbd_rx_done(lv[17]), .kbd_tx_done(lv[18]), .mouse_rx_done(lv[19]), .mouse_tx_done(lv[20]),
      .host_level_irq_input_n(irq_n));
   cia_host_model cia_host_model_i (.clk(clk), .reset_n(reset_n), .irq_n(irq_n), .irq_seen(seen));
   // Compare and count
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // One register access, data held until taken
   task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_sel <= 1'b1;
      bus_write <= w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_sel <= 1'b0;
      #1 q = rdata;
   endtask : acc
   task automatic rd(input logic [31:0] a, input logic [7:0] e, input string n);
      acc(1'b0, a, 8'h00);
      chk(n, q, e);
   endtask : rd
   function automatic logic [15:0] expv(input logic [20:0] l);
      return {l[20:17], ~l[16], |l[11:8], ~l[15], |l[7:4], ~l[14], l[2] | l[0], l[13:12], 4'h0};
   endfunction : expv
   // Reset values, enable readback, unmapped place
   task automatic t_regs;
      rd(CIA_OFS_EN_LOW, 8'h00, "en_low");
      rd(CIA_OFS_EN_HIGH, 8'h00, "en_high");
      rd(CIA_OFS_PEND_LOW, 8'h00, "pend_low");
      rd(CIA_OFS_PEND_HIGH, 8'h00, "pend_high");
      acc(1'b1, CIA_OFS_EN_LOW, 8'h5A);
      acc(1'b1, CIA_OFS_EN_HIGH, 8'hA5);
      acc(1'b1, CIA_OFS_EN_LOW + 1, 8'hFF);
      rd(CIA_OFS_EN_LOW, 8'h5A, "en_low_rw");
      rd(CIA_OFS_EN_HIGH, 8'hA5, "en_high_rw");
      rd(CIA_OFS_EN_LOW + 1, 8'h00, "unmapped");
      chk("irq_idle", seen, 0);
   endtask : t_regs
   // Edge causes latch, stay after source falls, clear by zero
   task automatic t_edge;
      acc(1'b1, CIA_OFS_EN_HIGH, 8'h00);
      acc(1'b1, CIA_OFS_EN_LOW, 8'h0F);
      for (int i = 0; i < 4; i++)
      begin
         if (i < 3)
            tmr[i] <= 1'b1;
         else
            ack_n <= 1'b0;
         cyc(2);
         tmr <= 3'h0;
         ack_n <= 1'b1;
         cyc(5);
         chk("irq_edge", seen, 1);
         rd(CIA_OFS_PEND_LOW, 8'h01 << i, "edge_latch");
         acc(1'b1, CIA_OFS_PEND_LOW, ~(8'h01 << i));
         rd(CIA_OFS_PEND_LOW, 8'h00, "edge_clear");
         cyc(2);
         chk("irq_clear", seen, 0);
      end
   endtask : t_edge
   // Walk each level source, masked and unmasked
   task automatic t_level(input logic [7:0] en);
      logic [15:0] e;
      acc(1'b1, CIA_OFS_EN_LOW, en);
      acc(1'b1, CIA_OFS_EN_HIGH, en);
      for (int i = 0; i < 21; i++)
      begin
         lv <= lv_idle ^ (21'h1 << i);
         e = expv(lv_idle ^ (21'h1 << i));
         cyc(4);
         acc(1'b1, CIA_OFS_PEND_HIGH, 8'hFF);
         acc(1'b1, CIA_OFS_PEND_LOW, 8'hF0);
         rd(CIA_OFS_PEND_LOW, e[7:0], "lvl_low");
         rd(CIA_OFS_PEND_HIGH, e[15:8], "lvl_high");
         chk("irq_lvl", seen, en[0] && e != 0);
      end
      lv <= lv_idle;
   endtask : t_level
   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Main sequence
   initial
   begin
      {reset_n, bus_sel, bus_write, bus_addr, bus_wdata, tmr} = '0;
      ack_n = 1'b1;
      lv = lv_idle;
      err_total = 0;
      total_checks = 0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      t_regs;
      t_edge;
      t_level(8'h00);
      t_level(8'hFF);
      report_and_stop;
   end
   // Watchdog
   initial
   begin
      repeat (4000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
endmodule : cia_irq_aggregator_tb
